// >>> sys_protect_defs.vh
`ifndef SYS_PROTECT_DEFS_VH
`define SYS_PROTECT_DEFS_VH

// System and reference clock rates
`define SYS_CLK_HZ          100000000
`define REF_CLK_HZ          32768

// Timeout selection and reset values of the protection control register
`define WDOG_SEL_W          3
`define WDOG_SEL_RESET      3'h3
`define WDOG_BASE_LOG2      9
`define WDOG_STEP_LOG2      2
`define WDOG_CNT_W          24
`define WDOG_CNT_ONE        24'h000001
`define BMON_SEL_W          2
`define BMON_SEL_RESET      2'h3
`define BMON_BASE_CYCLES    11'h080
`define BMON_CNT_W          11
`define BMON_CNT_ONE        11'h001

// Periodic timer divider end counts, divide by 4 or 2048
`define PIT_PLAIN_LAST      2'h3
`define PIT_PRESCALED_LAST  11'h7FF
`define PIT_PRE_W           11
`define PIT_PRE_ONE         11'h001

// Service sequence values
`define SVC_ARM             8'h55
`define SVC_FIRE            8'hAA

// Interrupt arbitration
`define ARB_ID_W            4
`define ARB_ID_RESET        4'hF
`define CM_ARB_ID           4'h8
`define WDOG_IRQ_LEVEL      3'h7

// Bus master arbitration levels and grant bit positions
`define BM_LEVEL_INTEG      3'h7
`define BM_LEVEL_CORE       3'h0
`define GNT_INTEG           0
`define GNT_CORE            1
`define GNT_MDMA            2
`define GNT_SERIAL_DMA_UNIT            3

`endif

// >>> sys_protect.v
// What this block does
// - Acknowledge with no participating module raises bus error internally.
// - Watchdog expiry gives system reset or level 7 interrupt, per select bit.
// - Watchdog has eight timeout periods chosen by a control field.
// - After reset watchdog is on, about one second, and resets on expiry.
// - Protection control accepts one write per reset; later writes ignored.
// - Periodic timer interrupts up to 15.94 s from 32.768 kHz; can disable.
// - A control decides whether timers keep counting during debug freeze.
// - Two show-cycle bits control show cycles and arbitration during them.
// - Eight mastership levels; integration 7, core 0, DMA units programmable.
// - Only integration, core, memory DMA and serial DMA may win mastership.
// - Watchdog level 7, timer level programmable, line n gives level n.
// - Matching acknowledge starts arbitration among same-level requesters.
// - Four-bit arbitration id, highest wins; ours resets to 15, lowerable.
// - Winner returns timer or watchdog vector; internal sources never autovector.
// - Autovector select bits give internal autovector for external levels.
// - Level 7 order watchdog, timer, external; below, timer beats external.
// - Bus monitor times address strobe; acknowledges end the timing.
// - Enabled bus monitor raises bus error on overlong cycles, acknowledges too.
// - Bus monitor limit programmable from 128 to 1K system clocks.
// - Watchdog restarts only after 55 then AA written, others may intervene.
// - Freeze control set halts watchdog and timer while freeze is asserted.
// - Spurious interrupt monitor is always active, no disable.
// - Clearing the enable bit in the single write disables the watchdog.
`include "sys_protect_defs.vh"

module sys_protect #(
  parameter TICK_CYCLES = `SYS_CLK_HZ / `REF_CLK_HZ
) (
  // Clock and reset
  input  wire        clk_in,
  input  wire        rst_b_in,
  // Protection control register write
  input  wire        pcr_wr_in,
  input  wire        pcr_watchdog_enable_bit_in,
  input  wire        pcr_irq_not_reset_in,
  input  wire [2:0]  pcr_wdog_period_in,
  input  wire        pcr_bus_monitor_enable_in,
  input  wire [1:0]  pcr_bmon_time_in,
  output wire        pcr_locked_out,
  // Watchdog service register write
  input  wire        svc_wr_in,
  input  wire [7:0]  svc_data_in,
  // Module configuration
  input  wire        freeze_timer_stop_in,
  input  wire        show_cycle_enable_hi_in,
  input  wire        show_cycle_enable_lo_in,
  input  wire        arb_id_wr_in,
  input  wire [3:0]  arb_id_data_in,
  input  wire        freeze_in,
  output wire        show_cycles_out,
  output wire        show_ext_arb_out,
  // Timer and vector configuration
  input  wire [7:0]  pit_modulus_in,
  input  wire        pit_prescale_in,
  input  wire [2:0]  pit_level_in,
  input  wire [7:0]  pit_vector_in,
  input  wire [7:0]  wdog_vector_in,
  input  wire [6:0]  autovector_select_in,
  // Interrupt sources
  input  wire [6:0]  external_interrupt_line_in,
  input  wire [2:0]  cm_irq_level_in,
  output reg  [2:0]  irq_level_out,
  // Interrupt acknowledge
  input  wire        iack_in,
  input  wire [2:0]  iack_level_in,
  output reg         iack_done_out,
  output reg  [7:0]  vector_out,
  output reg         vector_valid_out,
  output reg         autovector_out,
  output reg         cm_won_out,
  output reg  [3:0]  arb_id_out,
  // Bus cycle monitoring
  input  wire        address_strobe_in,
  input  wire        size_acknowledge_in,
  input  wire        bus_error_in,
  input  wire        halt_in,
  input  wire        autovector_strobe_in,
  input  wire        iack_cycle_in,
  output reg         bus_error_signal_out,
  output reg         wdog_reset_out,
  // Bus mastership
  input  wire        req_integ_in,
  input  wire        req_core_in,
  input  wire        req_mdma_in,
  input  wire        req_serial_dma_unit_in,
  input  wire [2:0]  mdma_level_in,
  input  wire [2:0]  serial_dma_unit_level_in,
  output reg  [3:0]  grant_out
);

  // Protection control state
  reg                      pcr_locked;
  reg                      wdog_en;
  reg                      wdog_irq_mode;
  reg [`WDOG_SEL_W-1:0]    wdog_sel;
  reg                      bmon_en;
  reg [`BMON_SEL_W-1:0]    bmon_sel;
  reg [`ARB_ID_W-1:0]      arb_id;
  // Timers
  reg [11:0]               tick_cnt;
  reg                      tick;
  reg [`WDOG_CNT_W-1:0]    wdog_cnt;
  reg                      svc_armed;
  reg [`PIT_PRE_W-1:0]     pit_pre;
  reg [7:0]                pit_cnt;
  reg                      pit_pending;
  reg                      wdog_pending;
  // Bus monitor
  reg [`BMON_CNT_W-1:0]    bmon_cnt;
  reg                      as_prev;
  reg                      bmon_done;

  wire timers_run = ~(freeze_in & freeze_timer_stop_in);

  // Watchdog period: 2^(9+2*sel) reference ticks, sel 3 about 1 s
  function [`WDOG_CNT_W-1:0] wdog_limit;
    input [`WDOG_SEL_W-1:0] sel;
    begin
      wdog_limit = {{(`WDOG_CNT_W-1){1'b0}}, 1'b1}
                   << (`WDOG_BASE_LOG2 + `WDOG_STEP_LOG2 * sel);
    end
  endfunction

  // Bus monitor limit: 128, 256, 512 or 1024 clocks
  function [`BMON_CNT_W-1:0] bmon_limit;
    input [`BMON_SEL_W-1:0] sel;
    begin
      bmon_limit = `BMON_BASE_CYCLES << sel;
    end
  endfunction

  assign pcr_locked_out   = pcr_locked;
  // Show cycles on with either bit; both set blocks external arbitration
  assign show_cycles_out  = show_cycle_enable_hi_in
                            | show_cycle_enable_lo_in;
  assign show_ext_arb_out = ~(show_cycle_enable_hi_in
                              & show_cycle_enable_lo_in);

  // Single write protection control register
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pcr_locked    <= 1'b0;
      wdog_en       <= 1'b1;
      wdog_irq_mode <= 1'b0;
      wdog_sel      <= `WDOG_SEL_RESET;
      bmon_en       <= 1'b1;
      bmon_sel      <= `BMON_SEL_RESET;
    end else if (pcr_wr_in && !pcr_locked) begin
      pcr_locked    <= 1'b1;
      wdog_en       <= pcr_watchdog_enable_bit_in;
      wdog_irq_mode <= pcr_irq_not_reset_in;
      wdog_sel      <= pcr_wdog_period_in;
      bmon_en       <= pcr_bus_monitor_enable_in;
      bmon_sel      <= pcr_bmon_time_in;
    end
  end

  // Arbitration id, resets to highest and may be rewritten
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      arb_id <= `ARB_ID_RESET;
    end else if (arb_id_wr_in) begin
      arb_id <= arb_id_data_in;
    end
  end

  // Reference tick divider, one pulse per 32.768 kHz period
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tick_cnt <= 12'h000;
      tick     <= 1'b0;
    end else if (tick_cnt == TICK_CYCLES[11:0] - 12'h001) begin
      tick_cnt <= 12'h000;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 12'h001;
      tick     <= 1'b0;
    end
  end

  // Watchdog counter and service sequence
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wdog_cnt       <= {`WDOG_CNT_W{1'b0}};
      svc_armed      <= 1'b0;
      wdog_reset_out <= 1'b0;
    end else begin
      wdog_reset_out <= 1'b0;
      if (svc_wr_in && svc_data_in == `SVC_ARM) begin
        svc_armed <= 1'b1;
      end else if (svc_wr_in && svc_data_in == `SVC_FIRE && svc_armed) begin
        svc_armed <= 1'b0;
      end
      if (!wdog_en) begin
        wdog_cnt <= {`WDOG_CNT_W{1'b0}};
      end else if (svc_wr_in && svc_data_in == `SVC_FIRE && svc_armed) begin
        wdog_cnt <= {`WDOG_CNT_W{1'b0}};
      end else if (tick && timers_run) begin
        if (wdog_cnt == wdog_limit(wdog_sel) - `WDOG_CNT_ONE) begin
          wdog_cnt       <= {`WDOG_CNT_W{1'b0}};
          wdog_reset_out <= ~wdog_irq_mode;
        end else begin
          wdog_cnt <= wdog_cnt + `WDOG_CNT_ONE;
        end
      end
    end
  end

  wire wdog_expire = wdog_en && tick && timers_run && wdog_irq_mode
                     && !(svc_wr_in && svc_data_in == `SVC_FIRE && svc_armed)
                     && wdog_cnt == wdog_limit(wdog_sel) - `WDOG_CNT_ONE;

  // Periodic timer: divide by 4 or 2048, then 8-bit modulus count
  wire pit_step = tick && timers_run && (pit_prescale_in
                  ? (pit_pre == `PIT_PRESCALED_LAST)
                  : (pit_pre[1:0] == `PIT_PLAIN_LAST));
  wire pit_expire = pit_step && pit_cnt == 8'h01;

  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pit_pre <= {`PIT_PRE_W{1'b0}};
      pit_cnt <= 8'h00;
    end else if (pit_modulus_in == 8'h00 && pit_cnt == 8'h00) begin
      pit_pre <= {`PIT_PRE_W{1'b0}};
    end else if (tick && timers_run) begin
      pit_pre <= pit_step ? {`PIT_PRE_W{1'b0}} : pit_pre + `PIT_PRE_ONE;
      if (pit_cnt == 8'h00 || pit_expire) begin
        pit_cnt <= pit_modulus_in; // New modulus taken at end of count
      end else if (pit_step) begin
        pit_cnt <= pit_cnt - 8'h01;
      end
    end
  end

  // Acknowledge participation and same-level arbitration
  wire [2:0] lv         = iack_level_in;
  wire       ext_match  = lv != 3'h0 && external_interrupt_line_in[lv - 3'h1];
  wire       wdog_match = wdog_pending && lv == `WDOG_IRQ_LEVEL;
  wire       pit_match  = pit_pending && pit_level_in == lv
                          && lv != 3'h0;
  wire       we_bid     = wdog_match | pit_match | ext_match;
  wire       cm_bid     = cm_irq_level_in == lv && lv != 3'h0;
  wire       we_win     = we_bid && (!cm_bid || arb_id > `CM_ARB_ID);
  wire       wdog_win   = iack_in && we_win && wdog_match;
  wire       pit_win    = iack_in && we_win && !wdog_match && pit_match;

  // Pending internal requests, set wins over clear
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pit_pending  <= 1'b0;
      wdog_pending <= 1'b0;
    end else begin
      pit_pending  <= pit_expire | (pit_pending & ~pit_win);
      wdog_pending <= wdog_expire | (wdog_pending & ~wdog_win);
    end
  end

  // Highest requested level, except a timer pending above the partner level hides external levels 1-5
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      irq_level_out <= 3'h0;
    end else if (wdog_pending || external_interrupt_line_in[6]) begin
      irq_level_out <= `WDOG_IRQ_LEVEL;
    end else begin
      irq_level_out <= cm_irq_level_in;
      if (pit_pending && pit_level_in > cm_irq_level_in) begin
        irq_level_out <= pit_level_in;
      end
      if (external_interrupt_line_in[5] && 3'h6 > cm_irq_level_in
          && !(pit_pending && pit_level_in > 3'h6)) begin
        irq_level_out <= 3'h6;
      end else if (!(pit_pending && pit_level_in > cm_irq_level_in)) begin
        if (external_interrupt_line_in[4] && 3'h5 > cm_irq_level_in)
          irq_level_out <= 3'h5;
        else if (external_interrupt_line_in[3] && 3'h4 > cm_irq_level_in)
          irq_level_out <= 3'h4;
        else if (external_interrupt_line_in[2] && 3'h3 > cm_irq_level_in)
          irq_level_out <= 3'h3;
        else if (external_interrupt_line_in[1] && 3'h2 > cm_irq_level_in)
          irq_level_out <= 3'h2;
        else if (external_interrupt_line_in[0] && 3'h1 > cm_irq_level_in)
          irq_level_out <= 3'h1;
      end
    end
  end

  // Bus monitor on address strobe duration
  wire bmon_term = size_acknowledge_in | bus_error_in | halt_in
                   | (autovector_strobe_in & iack_cycle_in);
  wire bmon_trip = bmon_en && address_strobe_in && !bmon_done && !bmon_term
                   && as_prev
                   && bmon_cnt == bmon_limit(bmon_sel) - `BMON_CNT_ONE;

  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      bmon_cnt  <= {`BMON_CNT_W{1'b0}};
      as_prev   <= 1'b0;
      bmon_done <= 1'b0;
    end else begin
      as_prev <= address_strobe_in;
      if (address_strobe_in && !as_prev) begin
        bmon_cnt  <= `BMON_CNT_ONE;
        bmon_done <= bmon_term;
      end else if (address_strobe_in && !bmon_done) begin
        if (bmon_term || bmon_trip) begin
          bmon_done <= 1'b1;
        end else begin
          bmon_cnt <= bmon_cnt + `BMON_CNT_ONE;
        end
      end
    end
  end

  // Acknowledge answer and bus error, one cycle after the request
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      iack_done_out        <= 1'b0;
      vector_out           <= 8'h00;
      vector_valid_out     <= 1'b0;
      autovector_out       <= 1'b0;
      cm_won_out           <= 1'b0;
      arb_id_out           <= 4'h0;
      bus_error_signal_out <= 1'b0;
    end else begin
      iack_done_out    <= iack_in;
      vector_valid_out <= 1'b0;
      autovector_out   <= 1'b0;
      cm_won_out       <= iack_in && cm_bid && !we_win;
      arb_id_out       <= (iack_in && we_bid) ? arb_id : 4'h0;
      bus_error_signal_out <= bmon_trip
                              | (iack_in & ~we_bid & ~cm_bid);
      if (wdog_win) begin
        vector_out       <= wdog_vector_in;
        vector_valid_out <= 1'b1;
      end else if (pit_win) begin
        vector_out       <= pit_vector_in;
        vector_valid_out <= 1'b1;
      end else if (iack_in && we_win) begin
        autovector_out <= autovector_select_in[lv - 3'h1];
      end
    end
  end

  // Bus mastership among the four legal masters: integration first, DMA units by level, core last
  reg [2:0] best;
  always @* begin
    grant_out = 4'h0;
    best      = 3'h0;
    if (req_integ_in) begin
      grant_out[`GNT_INTEG] = 1'b1;
    end else begin
      if (req_mdma_in) begin
        grant_out[`GNT_MDMA] = 1'b1;
        best = mdma_level_in;
      end
      if (req_serial_dma_unit_in && (!req_mdma_in || serial_dma_unit_level_in > best)) begin
        grant_out = 4'h0;
        grant_out[`GNT_SERIAL_DMA_UNIT] = 1'b1;
      end
      if (req_core_in && !req_mdma_in && !req_serial_dma_unit_in) begin
        grant_out[`GNT_CORE] = 1'b1;
      end
    end
  end

endmodule

// >>> sys_protect_properties.sv
`include "sys_protect_defs.vh"
module sys_protect_properties (
  // Clock and reset
  input wire logic       clk_in,
  input wire logic       rst_b_in,
  // Acknowledge
  input wire logic       iack_in,
  input wire logic [2:0] iack_level_in,
  input wire logic       iack_done_out,
  input wire logic       vector_valid_out,
  input wire logic       autovector_out,
  input wire logic       cm_won_out,
  // Requests
  input wire logic [6:0] external_interrupt_line_in,
  input wire logic [2:0] cm_irq_level_in,
  input wire logic [2:0] irq_level_out,
  input wire logic       bus_error_signal_out,
  // Configuration and mastership
  input wire logic       show_cycle_enable_hi_in,
  input wire logic       show_cycle_enable_lo_in,
  input wire logic       show_cycles_out,
  input wire logic       show_ext_arb_out,
  input wire logic [3:0] grant_out,
  input wire logic       req_integ_in,
  // Protection and bus monitor
  input wire logic       pcr_wr_in,
  input wire logic       pcr_locked_out,
  input wire logic       address_strobe_in,
  input wire logic       wdog_reset_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);

  // Acknowledge answer and its exclusive outcomes
  chk_iack_answer: assert property (iack_in |=> iack_done_out)
    else $error("acknowledge not answered");
  chk_unclaimed_bus_error_signal: assert property (iack_in && iack_level_in != 3'h0
    && irq_level_out < iack_level_in && cm_irq_level_in != iack_level_in
    && !external_interrupt_line_in[iack_level_in - 3'h1]
    |=> bus_error_signal_out) else $error("unclaimed acknowledge passed");
  chk_vector_excl: assert property (vector_valid_out |->
    !autovector_out && !cm_won_out) else $error("vector with autovector");
  chk_cm_win: assert property (cm_won_out |->
    iack_done_out && !vector_valid_out) else $error("bad partner win");
  // Configuration and mastership decode
  chk_show_decode: assert property (
    show_cycles_out == (show_cycle_enable_hi_in || show_cycle_enable_lo_in)
    && show_ext_arb_out == !(show_cycle_enable_hi_in && show_cycle_enable_lo_in))
    else $error("show cycle decode wrong");
  chk_grant_integ: assert property ($onehot0(grant_out)
    && grant_out[`GNT_INTEG] == req_integ_in) else $error("grant wrong");
  // Protection write lock and timer outputs
  chk_lock_once: assert property (pcr_wr_in && !pcr_locked_out
    |=> pcr_locked_out [*4]) else $error("protection write not locked");
  chk_bmon_early: assert property ($rose(address_strobe_in) && !iack_in
    |=> !bus_error_signal_out [*8]) else $error("bus monitor tripped early");
  chk_reset_pulse: assert property (wdog_reset_out |=> !wdog_reset_out)
    else $error("reset request longer than a cycle");
endmodule

bind sys_protect sys_protect_properties chk_u (
  .clk_in, .rst_b_in, .iack_in, .iack_level_in, .iack_done_out,
  .vector_valid_out, .autovector_out, .cm_won_out,
  .external_interrupt_line_in, .cm_irq_level_in, .irq_level_out,
  .bus_error_signal_out, .show_cycle_enable_hi_in, .show_cycle_enable_lo_in,
  .show_cycles_out, .show_ext_arb_out, .grant_out, .req_integ_in,
  .pcr_wr_in, .pcr_locked_out, .address_strobe_in, .wdog_reset_out
);

// >>> core_model.sv
module core_model (
  // Answers from the block
  input  wire logic       clk_in,
  input  wire logic       iack_done_out,
  input  wire logic [7:0] vector_out,
  input  wire logic       vector_valid_out,
  input  wire logic       autovector_out,
  input  wire logic       cm_won_out,
  input  wire logic [3:0] arb_id_out,
  input  wire logic       bus_error_signal_out,
  // Bus cycle lines driven by the core
  output logic            iack_in,
  output logic [2:0]      iack_level_in,
  output logic            iack_cycle_in,
  output logic            address_strobe_in,
  output logic            autovector_strobe_in,
  output logic            size_acknowledge_in,
  output logic            halt_in,
  output logic            bus_error_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got_vec;
  logic [3:0] got_id;
  logic [3:0] got_flags;

  // Idle bus at time zero
  initial begin
    {iack_in, iack_level_in, iack_cycle_in, address_strobe_in} = '0;
    {autovector_strobe_in, size_acknowledge_in, halt_in, bus_error_in} = '0;
  end

  // Acknowledge cycle; flags are {valid, autovector, partner win, error}
  task automatic ack(input logic [2:0] lvl);
    @(negedge clk_in);
    {iack_in, iack_cycle_in, address_strobe_in} = 3'h7;
    iack_level_in = lvl;
    @(negedge clk_in);
    iack_in = 1'b0;
    got_vec = vector_out;
    got_id = arb_id_out;
    got_flags = {vector_valid_out, autovector_out, cm_won_out,
                 bus_error_signal_out};
    // Nobody inside answered: external logic ends it with the strobe
    if (iack_done_out === 1'b1 && got_flags === 4'h0)
      autovector_strobe_in = 1'b1;
    @(negedge clk_in);
    {iack_cycle_in, address_strobe_in, autovector_strobe_in} = 3'h0;
    iack_level_in = ~lvl;
  endtask

  // Plain cycle; kind 1 size ack, 2 halt, 3 bus error, 0 no answer
  task automatic bus_cycle(input int kind, dly, max, output int n);
    n = 0;
    @(negedge clk_in);
    address_strobe_in = 1'b1;
    for (int i = 1; i <= max && n == 0; i++) begin
      @(negedge clk_in);
      if (kind != 0 && i == dly)
        {bus_error_in, halt_in, size_acknowledge_in} = 3'h1 << (kind - 1);
      if (kind != 0 && i == dly + 1) begin
        {bus_error_in, halt_in, size_acknowledge_in} = 3'h0;
        address_strobe_in = 1'b0;
      end
      if (bus_error_signal_out === 1'b1)
        n = i;
    end
    {bus_error_in, halt_in, size_acknowledge_in, address_strobe_in} = 4'h0;
  endtask
endmodule

// >>> testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // Bench driven inputs, then block and core model outputs
  logic       clk_in, rst_b_in, pcr_wr_in, pcr_watchdog_enable_bit_in;
  logic       pcr_irq_not_reset_in, pcr_bus_monitor_enable_in, svc_wr_in;
  logic       freeze_timer_stop_in, show_cycle_enable_hi_in, arb_id_wr_in;
  logic       show_cycle_enable_lo_in, freeze_in, pit_prescale_in;
  logic       req_integ_in, req_core_in, req_mdma_in, req_serial_dma_unit_in;
  logic [1:0] pcr_bmon_time_in;
  logic [2:0] pcr_wdog_period_in, pit_level_in, cm_irq_level_in;
  logic [2:0] mdma_level_in, serial_dma_unit_level_in, iack_level_in;
  logic [3:0] arb_id_data_in, arb_id_out, grant_out;
  logic [6:0] autovector_select_in, external_interrupt_line_in;
  logic [7:0] svc_data_in, pit_modulus_in, pit_vector_in, wdog_vector_in;
  logic [7:0] vector_out;
  logic [2:0] irq_level_out;
  logic       iack_in, iack_cycle_in, address_strobe_in, size_acknowledge_in;
  logic       halt_in, bus_error_in, autovector_strobe_in, iack_done_out;
  logic       vector_valid_out, autovector_out, cm_won_out, pcr_locked_out;
  logic       bus_error_signal_out, wdog_reset_out;
  logic       show_cycles_out, show_ext_arb_out;
  int         miscompares, tests_run, cyc, resets, n, t0;
  localparam logic [3:0] MREQ [5] = '{4'hF, 4'h7, 4'h7, 4'h4, 4'h0};
  localparam logic [5:0] MLVL [5] = '{6'h1D, 6'h1D, 6'h2D, 6'h00, 6'h00};
  localparam logic [3:0] MGNT [5] = '{4'h1, 4'h8, 4'h4, 4'h2, 4'h0};

  sys_protect #(.TICK_CYCLES(4)) dut_u (.*);
  core_model core_u (.*);

  // Clock, cycle count and reset request count
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (wdog_reset_out === 1'b1)
      resets <= resets + 1;
  end

  task automatic check(input string name, input logic [15:0] exp, got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
    end
  endtask
  task automatic complete_run();
    if (miscompares == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Fields {enable, irq, period, monitor enable, monitor time}
  task automatic pcr(input logic [7:0] v);
    @(negedge clk_in);
    {pcr_watchdog_enable_bit_in, pcr_irq_not_reset_in} = v[7:6];
    {pcr_wdog_period_in, pcr_bus_monitor_enable_in} = v[5:2];
    pcr_bmon_time_in = v[1:0];
    pcr_wr_in = 1'b1;
    @(negedge clk_in);
    pcr_wr_in = 1'b0;
  endtask
  task automatic svc(input logic [7:0] d);
    @(negedge clk_in);
    svc_data_in = d;
    svc_wr_in = 1'b1;
    @(negedge clk_in);
    svc_wr_in = 1'b0;
  endtask
  task automatic do_reset();
    rst_b_in = 1'b0;
    repeat (10) @(negedge clk_in);
    rst_b_in = 1'b1;
  endtask

  // Hang guard
  initial begin
    #400000;
    miscompares++;
    complete_run();
  end

  initial begin
    {pcr_wr_in, svc_wr_in, arb_id_wr_in, freeze_in, freeze_timer_stop_in} = 0;
    {pcr_watchdog_enable_bit_in, pcr_irq_not_reset_in, pcr_wdog_period_in} = 0;
    {pcr_bus_monitor_enable_in, pcr_bmon_time_in, svc_data_in} = 0;
    {show_cycle_enable_hi_in, show_cycle_enable_lo_in, arb_id_data_in} = 0;
    {req_integ_in, req_core_in, req_mdma_in, req_serial_dma_unit_in} = 0;
    {mdma_level_in, serial_dma_unit_level_in, pit_level_in, cm_irq_level_in} = 0;
    {pit_modulus_in, pit_prescale_in, autovector_select_in} = 0;
    external_interrupt_line_in = 7'h00;
    pit_vector_in = 8'h3C;
    wdog_vector_in = 8'h5A;
    do_reset();
    check("pcr_locked_out", 0, pcr_locked_out);
    for (int i = 0; i < 4; i++) begin
      @(negedge clk_in);
      {show_cycle_enable_hi_in, show_cycle_enable_lo_in} = 2'(i);
      #1 check("show", {i != 0, i != 3}, {show_cycles_out, show_ext_arb_out});
    end
    for (int i = 0; i < 5; i++) begin
      @(negedge clk_in);
      {req_integ_in, req_core_in, req_mdma_in, req_serial_dma_unit_in} = MREQ[i];
      {mdma_level_in, serial_dma_unit_level_in} = MLVL[i];
      #1 check("grant_out", MGNT[i], grant_out);
    end
    core_u.bus_cycle(0, 0, 1100, n);
    check("bmon 1024", 1, n >= 1023 && n <= 1025);
    pcr(8'hC4);
    check("pcr_locked_out", 1, pcr_locked_out);
    pcr(8'h07);
    svc(8'h55);
    svc(8'hAA);
    for (int k = 1; k < 4; k++) begin
      core_u.bus_cycle(k, 20, 200, n);
      check("terminated", 0, n);
    end
    core_u.bus_cycle(0, 0, 300, n);
    check("bmon 128", 1, n >= 127 && n <= 129);
    // Service with a stray value between and a lone AA afterwards
    svc(8'h55);
    svc(8'h33);
    svc(8'hAA);
    t0 = cyc;
    repeat (1000) @(negedge clk_in);
    svc(8'hAA);
    for (int i = 0; i < 1500 && irq_level_out !== 3'h7; i++) @(negedge clk_in);
    check("wdog irq time", 1, cyc - t0 >= 2040 && cyc - t0 <= 2056);
    wdog_vector_in = 8'hA5;
    core_u.ack(3'h7);
    check("wdog vector", 16'hA58F, {core_u.got_vec, core_u.got_flags, core_u.got_id});
    check("irq_level_out", 0, irq_level_out);
    svc(8'h55);
    svc(8'hAA);
    core_u.ack(3'h3);
    check("spurious", 1, core_u.got_flags);
    // Timer against external line at level 4, held until won
    {pit_level_in, pit_modulus_in} = {3'h4, 8'h01};
    repeat (40) @(negedge clk_in);
    {pit_modulus_in, external_interrupt_line_in, autovector_select_in} = 22'h408;
    repeat (20) @(negedge clk_in);
    core_u.ack(3'h4);
    check("pit wins", 16'h3C8F, {core_u.got_vec, core_u.got_flags, core_u.got_id});
    core_u.ack(3'h4);
    check("autovector", 4'h4, core_u.got_flags);
    autovector_select_in = 7'h0;
    cm_irq_level_in = 3'h4;
    core_u.ack(3'h4);
    check("ours wins", 8'h0F, {core_u.got_flags, core_u.got_id});
    @(negedge clk_in);
    {arb_id_data_in, arb_id_wr_in} = {4'h3, 1'b1};
    @(negedge clk_in);
    arb_id_wr_in = 1'b0;
    core_u.ack(3'h4);
    check("partner wins", 4'h2, core_u.got_flags);
    {cm_irq_level_in, external_interrupt_line_in} = 0;
    // Freeze with and without the stop control
    {pit_level_in, pit_modulus_in, freeze_in} = {3'h2, 8'h01, 1'b1};
    pit_vector_in = 8'hC3;
    for (int i = 0; i < 60 && irq_level_out !== 3'h2; i++) @(negedge clk_in);
    check("run in freeze", 2, irq_level_out);
    freeze_timer_stop_in = 1'b1;
    core_u.ack(3'h2);
    check("frozen vector", 12'hC38, {core_u.got_vec, core_u.got_flags});
    repeat (100) @(negedge clk_in);
    check("frozen", 0, irq_level_out);
    freeze_in = 1'b0;
    for (int i = 0; i < 60 && irq_level_out !== 3'h2; i++) @(negedge clk_in);
    check("thawed", 2, irq_level_out);
    pit_modulus_in = 8'h00;
    core_u.ack(3'h2);
    // Reset mode expiry, then a disabled watchdog
    do_reset();
    pcr(8'h84);
    svc(8'h55);
    svc(8'hAA);
    t0 = cyc;
    for (int i = 0; i < 2200 && wdog_reset_out !== 1'b1; i++) @(negedge clk_in);
    check("wdog reset time", 1, cyc - t0 >= 2040 && cyc - t0 <= 2056);
    do_reset();
    pcr(8'h04);
    t0 = resets;
    {pit_prescale_in, pit_level_in, pit_modulus_in} = {1'b1, 3'h3, 8'h01};
    repeat (8000) @(negedge clk_in);
    check("prescaled early", 0, irq_level_out);
    repeat (300) @(negedge clk_in);
    check("disabled", 3, {13'(resets - t0), irq_level_out});
    complete_run();
  end
endmodule
